/* File: hw/dual_pwm_out.sv */
// dual channel pulse width output, top level
// Functional notes
// - stepper mode reports output pulse count, up for positive, down for negative
// - low-side channels set independently, over 30000 duty steps, period adjustable
// - after reset: pwm mode, 250 Hz base, 10-bit duty on high side
// - image per channel: 16-bit data word plus 8-bit control/status
// - default image is six bytes; mapping changeable by configuration
// - base period and duty both configurable through 16-bit values
// - frequency modulation and pulse-with-direction modes besides pwm
// - 100 ms without process data: watchdog flag, run indicator off
// - on watchdog overflow outputs take user fallback setpoints
// - high-side setpoint signed: 0x0000 0%, 0x3FFF 50%, 0x7FFF 100%
// - high-side duty uses at most 10 bits, low bits dropped
// - low-side setpoint is a 16-bit unsigned value
// - low-side sweeps twice: 0x7FFF/0xFFFF 0%, 0x0000/0x8000 100%
// - control bit 0 rising, process mode: counter loads data word
`timescale 1ns/1ps
`include "pwm_out_map.svh"

module dual_pwm_out #(
    parameter int unsigned WD_CYCLES = `WD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic lowSideVariant,
    input wire logic pdStrobe,
    input wire pwm_out_pkg::procOut_t pdOut,
    input wire logic cfgWrite,
    input wire pwm_out_pkg::mode_t cfgMode,
    input wire logic [15:0] cfgPeriodUs,
    input wire logic [15:0] cfgFallback0,
    input wire logic [15:0] cfgFallback1,
    input wire logic cfgDataOnlyMap,
    output pwm_out_pkg::procIn_t pdIn,
    output logic [1:0] pwmOut,
    output logic [1:0] dirOut,
    output logic runLed,
    output logic wdOverflow,
    output logic [2:0] imageBytes
);

    // ***********************************
    // setpoint decode
    // ***********************************
    // high side: signed, 10 bits kept, negative clamps to off
    function automatic logic [15:0] decodeHigh(input logic [15:0] sp);
        logic [15:0] d;
        d = 16'h0000;
        if (sp[15]) begin
            d = 16'h0000;
        end else if (sp[14:5] == 10'h3FF) begin
            d = `DUTY_FULL;
        end else begin
            d = {1'b0, sp[14:5], 5'h00};
        end
        return d;
    endfunction

    // low side: unsigned, inverted, repeats every half range
    function automatic logic [15:0] decodeLow(input logic [15:0] sp);
        logic [15:0] d;
        d = 16'h0000;
        if (sp[14:0] == 15'h0000) begin
            d = `DUTY_FULL;
        end else begin
            d = {1'b0, `LOW_SPAN - sp[14:0]};
        end
        return d;
    endfunction

    function automatic logic [15:0] decodeDuty(input logic low, input logic [15:0] sp);
        return low ? decodeLow(sp) : decodeHigh(sp);
    endfunction

    // ***********************************
    // configuration
    // ***********************************
    pwm_out_pkg::mode_t mode_r, mode_nxt;
    logic [15:0] period_r, period_nxt;
    logic [15:0] fallback0_r, fallback0_nxt;
    logic [15:0] fallback1_r, fallback1_nxt;
    logic dataOnly_r, dataOnly_nxt;
    logic [21:0] periodCycles;

    // a zero period would wrap the boundary compare to the full counter span, so it is raised to one
    always_comb begin
        mode_nxt = mode_r;
        period_nxt = period_r;
        fallback0_nxt = fallback0_r;
        fallback1_nxt = fallback1_r;
        dataOnly_nxt = dataOnly_r;
        if (cfgWrite) begin
            mode_nxt = cfgMode;
            period_nxt = (cfgPeriodUs == 16'h0000) ? 16'h0001 : cfgPeriodUs;
            fallback0_nxt = cfgFallback0;
            fallback1_nxt = cfgFallback1;
            dataOnly_nxt = cfgDataOnlyMap;
        end
    end

    // defaults come up as pwm at 250 Hz
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_r <= pwm_out_pkg::MODE_PWM;
            period_r <= `DEF_PERIOD_US;
            fallback0_r <= `DEF_FALLBACK;
            fallback1_r <= `DEF_FALLBACK;
            dataOnly_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            period_r <= period_nxt;
            fallback0_r <= fallback0_nxt;
            fallback1_r <= fallback1_nxt;
            dataOnly_r <= dataOnly_nxt;
        end
    end

    assign periodCycles = 22'(period_r) * 22'(`CLK_MHZ);

    // ***********************************
    // process image latch and watchdog
    // ***********************************
    logic [15:0] setp_r [2];
    logic [15:0] setp_nxt [2];
    logic [7:0] ctrl_r [2];
    logic [7:0] ctrl_nxt [2];
    logic [1:0] ctrlPrev_r, ctrlPrev_nxt;
    logic [22:0] wdCnt_r, wdCnt_nxt;
    logic wd_nxt, run_nxt;
    logic wdExpire;

    assign wdExpire = (wdCnt_r == 23'(WD_CYCLES - 1));

    // any received image restarts the watchdog
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            setp_nxt[i] = setp_r[i];
            ctrl_nxt[i] = ctrl_r[i];
            if (pdStrobe) begin
                setp_nxt[i] = pdOut[i].data;
                // data-only mapping carries no control byte
                ctrl_nxt[i] = dataOnly_r ? 8'h00 : pdOut[i].ctrl;
            end
            ctrlPrev_nxt[i] = ctrl_r[i][`CTRL_LOAD_BIT];
        end
        wdCnt_nxt = wdCnt_r;
        wd_nxt = wdOverflow;
        if (pdStrobe) begin
            wdCnt_nxt = 23'd0;
            wd_nxt = 1'b0;
        end else if (wdExpire) begin
            wd_nxt = 1'b1;
        end else begin
            wdCnt_nxt = wdCnt_r + 23'd1;
        end
        run_nxt = pdStrobe | (runLed & ~wd_nxt);
    end

    // run indicator stays dark until the first image arrives
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 2; i++) begin
                setp_r[i] <= 16'h0000;
                ctrl_r[i] <= 8'h00;
            end
            ctrlPrev_r <= 2'b00;
            wdCnt_r <= 23'd0;
            wdOverflow <= 1'b0;
            runLed <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                setp_r[i] <= setp_nxt[i];
                ctrl_r[i] <= ctrl_nxt[i];
            end
            ctrlPrev_r <= ctrlPrev_nxt;
            wdCnt_r <= wdCnt_nxt;
            wdOverflow <= wd_nxt;
            runLed <= run_nxt;
        end
    end

    // ***********************************
    // channel drive
    // ***********************************
    logic [15:0] active [2];
    logic [15:0] duty [2];
    logic [15:0] count [2];
    logic [1:0] loadCount;
    logic counting;

    assign counting = (mode_r == pwm_out_pkg::MODE_STEPPER);

    // fallback replaces the last setpoint while the watchdog is out
    always_comb begin
        active[0] = wdOverflow ? fallback0_r : setp_r[0];
        active[1] = wdOverflow ? fallback1_r : setp_r[1];
        for (int i = 0; i < 2; i++) begin
            duty[i] = decodeDuty(lowSideVariant, active[i]);
            // edge of bit 0 only counts in process data mode
            loadCount[i] = counting & ctrl_r[i][`CTRL_LOAD_BIT]
                & ~ctrlPrev_r[i] & ~ctrl_r[i][`CTRL_REG_BIT];
        end
    end

    // both channels share mode and period, each has its own setpoint
    for (genvar g = 0; g < 2; g++) begin : gChan
        pwm_channel uChan (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .mode(mode_r),
            .periodCycles(periodCycles),
            .duty(duty[g]),
            .freqWord(active[g]),
            .loadCount(loadCount[g]),
            .loadValue(setp_r[g]),
            .pwmOut(pwmOut[g]),
            .dirOut(dirOut[g]),
            .count(count[g])
        );
    end

    // ***********************************
    // returned image
    // ***********************************
    pwm_out_pkg::procIn_t pdIn_nxt;
    logic [2:0] bytes_nxt;

    // status reads zero when the mapping carries no status byte
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pdIn_nxt[i].data = counting ? count[i] : 16'h0000;
            pdIn_nxt[i].status = 8'h00;
            if (!dataOnly_r) begin
                pdIn_nxt[i].status[`STAT_WD_BIT] = wdOverflow;
                pdIn_nxt[i].status[`STAT_OUT_BIT] = pwmOut[i];
                pdIn_nxt[i].status[`STAT_DIR_BIT] = dirOut[i];
            end
        end
        bytes_nxt = dataOnly_r ? `IMAGE_BYTES_DATA : `IMAGE_BYTES_FULL;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pdIn <= '0;
            imageBytes <= `IMAGE_BYTES_FULL;
        end else begin
            pdIn <= pdIn_nxt;
            imageBytes <= bytes_nxt;
        end
    end

    // ***********************************
    // checks
    // ***********************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_silentExpire;
        wdExpire && !pdStrobe;
    endsequence
    property p_wdFire;
        s_silentExpire |=> wdOverflow && !runLed;
    endproperty
    a_wdFire: assert property (p_wdFire) else $error("watchdog did not fire");

    property p_wdClear;
        pdStrobe |=> !wdOverflow && wdCnt_r == 23'd0 && runLed;
    endproperty
    a_wdClear: assert property (p_wdClear) else $error("watchdog not restarted");

    property p_fallback;
        wdOverflow |-> active[0] == fallback0_r && active[1] == fallback1_r;
    endproperty
    a_fallback: assert property (p_fallback) else $error("fallback not applied");

    property p_highNeg;
        !lowSideVariant && active[0][15] |-> duty[0] == 16'h0000;
    endproperty
    a_highNeg: assert property (p_highNeg) else $error("negative setpoint not off");

    property p_highRes;
        !lowSideVariant |-> duty[0][4:0] == 5'h00;
    endproperty
    a_highRes: assert property (p_highRes) else $error("duty finer than 10 bits");

    property p_lowWrap;
        lowSideVariant && active[1][14:0] == 15'h7FFF |-> duty[1] == 16'h0000;
    endproperty
    a_lowWrap: assert property (p_lowWrap) else $error("low side zero wrong");

    property p_loadEdge;
        loadCount[0] |-> ##1 !loadCount[0];
    endproperty
    a_loadEdge: assert property (p_loadEdge) else $error("load not an edge");

endmodule

/* File: hw/pwm_out_map.svh */
// constants for the dual channel pulse width output
`ifndef PWM_OUT_MAP_SVH
`define PWM_OUT_MAP_SVH

// ***********************************
// clock and timing
// ***********************************
`define CLK_HZ 50_000_000
`define CLK_MHZ 50
`define WD_TIME_MS 100
`define WD_CYCLES (`WD_TIME_MS * (`CLK_HZ / 1000))
`define NCO_HZ_PER_UNIT 8

// ***********************************
// reset values
// ***********************************
`define DEF_PERIOD_US 16'h0FA0
`define DEF_FALLBACK 16'h0000

// ***********************************
// control and status byte fields
// ***********************************
`define CTRL_LOAD_BIT 0
`define CTRL_REG_BIT 7
`define STAT_WD_BIT 0
`define STAT_OUT_BIT 1
`define STAT_DIR_BIT 2

// ***********************************
// setpoint decode and image size
// ***********************************
`define DUTY_FULL 16'h8000
`define LOW_SPAN 15'h7FFF
`define IMAGE_BYTES_FULL 3'h6
`define IMAGE_BYTES_DATA 3'h4

`endif

/* File: hw/pwm_out_pkg.sv */
// types for the dual channel pulse width output
package pwm_out_pkg;

    // ***********************************
    // operating modes
    // ***********************************
    typedef enum logic [1:0] {
        MODE_PWM,
        MODE_FREQ_MODULATION,
        MODE_STEPPER
    } mode_t;

    // ***********************************
    // process image, one channel
    // ***********************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] data;
    } chanOut_t;

    typedef struct packed {
        logic [7:0] status;
        logic [15:0] data;
    } chanIn_t;

    typedef chanOut_t [1:0] procOut_t;
    typedef chanIn_t [1:0] procIn_t;

endpackage

/* File: hw/pwm_channel.sv */
// one output channel: pwm, frequency modulation and step pulses
`timescale 1ns/1ps
`include "pwm_out_map.svh"

module pwm_channel (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire pwm_out_pkg::mode_t mode,
    input wire logic [21:0] periodCycles,
    input wire logic [15:0] duty,
    input wire logic [15:0] freqWord,
    input wire logic loadCount,
    input wire logic [15:0] loadValue,
    output logic pwmOut,
    output logic dirOut,
    output logic [15:0] count
);
    logic [21:0] cnt_r, cnt_nxt, onCycles_r, onCycles_nxt;
    logic [25:0] acc_r, acc_nxt;
    logic sq_r, sq_nxt, out_nxt, dir_nxt;
    logic [15:0] count_nxt, mag;
    logic [37:0] prod;
    logic [26:0] accSum;
    logic boundary, wrap, rise, neg, stepper;

    // ***********************************
    // period counter and duty latch
    // ***********************************
    // full scale duty is 0x8000, so the product lands on the period
    assign prod = 38'(periodCycles) * 38'(duty);
    assign boundary = (cnt_r >= periodCycles - 22'd1);
    assign stepper = (mode == pwm_out_pkg::MODE_STEPPER);
    assign neg = freqWord[15];
    assign mag = neg ? 16'(-freqWord) : freqWord;
    // oscillator runs at twice the wanted rate, each wrap toggles
    assign accSum = 27'(acc_r) + 27'({mag, 4'h0});
    assign wrap = (accSum >= 27'(`CLK_HZ));
    assign rise = wrap & ~sq_r;

    always_comb begin
        cnt_nxt = boundary ? 22'd0 : cnt_r + 22'd1;
        // new duty only at the boundary, no runt pulses
        onCycles_nxt = boundary ? prod[36:15] : onCycles_r;
        // phase continuous, so a new frequency never glitches
        acc_nxt = wrap ? 26'(accSum - 27'(`CLK_HZ)) : accSum[25:0];
        sq_nxt = wrap ? ~sq_r : sq_r;
        count_nxt = count;
        if (loadCount) begin
            count_nxt = loadValue;
        end else if (stepper && rise) begin
            count_nxt = neg ? count - 16'd1 : count + 16'd1;
        end
        dir_nxt = stepper & neg;
        case (mode)
            pwm_out_pkg::MODE_PWM: out_nxt = (cnt_r < onCycles_r);
            pwm_out_pkg::MODE_FREQ_MODULATION: out_nxt = sq_r;
            pwm_out_pkg::MODE_STEPPER: out_nxt = sq_r;
            default: out_nxt = 1'b0;
        endcase
    end

    // registers only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 22'd0;
            onCycles_r <= 22'd0;
            acc_r <= 26'd0;
            sq_r <= 1'b0;
            count <= 16'h0000;
            pwmOut <= 1'b0;
            dirOut <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            onCycles_r <= onCycles_nxt;
            acc_r <= acc_nxt;
            sq_r <= sq_nxt;
            count <= count_nxt;
            pwmOut <= out_nxt;
            dirOut <= dir_nxt;
        end
    end

    // ***********************************
    // checks
    // ***********************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_upStep;
        stepper && rise && !loadCount && !neg;
    endsequence
    property p_countUp;
        s_upStep |=> count == $past(count) + 16'd1;
    endproperty
    a_countUp: assert property (p_countUp) else $error("count did not step up");

    property p_countDown;
        stepper && rise && !loadCount && neg |=> count == $past(count) - 16'd1;
    endproperty
    a_countDown: assert property (p_countDown) else $error("count did not step down");

    property p_load;
        loadCount |=> count == $past(loadValue);
    endproperty
    a_load: assert property (p_load) else $error("count not loaded");

    property p_holdDuty;
        !boundary |=> $stable(onCycles_r);
    endproperty
    a_holdDuty: assert property (p_holdDuty) else $error("duty changed mid period");

    property p_dir;
        ##1 dirOut == $past(stepper && neg);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");

endmodule

/* File: tb/coupler_model.sv */
// bus coupler model: sends cyclic process images to the output block
`timescale 1ns/1ps

module coupler_model (
    input wire logic clk_sys,
    output pwm_out_pkg::procOut_t pdOut,
    output logic pdStrobe
);
    // ***********************************
    // idle bus
    // ***********************************
    initial begin
        pdStrobe = 1'b0;
        pdOut = '0;
    end

    // one image per call: word plus byte per channel, strobed for one cycle
    task automatic send(input pwm_out_pkg::procOut_t img);
        @(posedge clk_sys);
        pdOut <= img;
        pdStrobe <= 1'b1;
        @(posedge clk_sys);
        pdStrobe <= 1'b0;
        pdOut <= ~img; // released bus shows junk, never the stale image
    endtask
endmodule

/* File: tb/dual_pwm_out_test.sv */
// self-checking bench for the dual channel pulse width output
`timescale 1ns/1ps

module dual_pwm_out_test;
    localparam int WD = 1000; // short watchdog so the run stays brief
    logic clk_sys;
    logic resetn;
    logic lowSideVariant;
    logic cfgWrite;
    logic cfgDataOnlyMap;
    pwm_out_pkg::mode_t cfgMode;
    logic [15:0] cfgPeriodUs;
    logic [15:0] cfgFallback0;
    logic [15:0] cfgFallback1;
    logic pdStrobe;
    pwm_out_pkg::procOut_t pdOut;
    pwm_out_pkg::procIn_t pdIn;
    logic [1:0] pwmOut;
    logic [1:0] dirOut;
    logic runLed;
    logic wdOverflow;
    logic [2:0] imageBytes;
    int errorCnt = 0;
    int checks = 0;

    // ***********************************
    // clock, partner and design
    // ***********************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    coupler_model cpl_u (.clk_sys(clk_sys), .pdOut(pdOut), .pdStrobe(pdStrobe));

    dual_pwm_out #(.WD_CYCLES(WD)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .lowSideVariant(lowSideVariant),
        .pdStrobe(pdStrobe), .pdOut(pdOut), .cfgWrite(cfgWrite), .cfgMode(cfgMode),
        .cfgPeriodUs(cfgPeriodUs), .cfgFallback0(cfgFallback0), .cfgFallback1(cfgFallback1),
        .cfgDataOnlyMap(cfgDataOnlyMap), .pdIn(pdIn), .pwmOut(pwmOut), .dirOut(dirOut),
        .runLed(runLed), .wdOverflow(wdOverflow), .imageBytes(imageBytes)
    );

    // ***********************************
    // shared tasks
    // ***********************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic testDone;
        if (errorCnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic resetDut(input logic low);
        @(posedge clk_sys);
        resetn <= 1'b0;
        lowSideVariant <= low; // variant only changes while held in reset
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask

    // period fixed at 2 us (100 cycles) so a duty count fits one short window
    task automatic cfg(input pwm_out_pkg::mode_t m, input logic [15:0] fb0, input logic [15:0] fb1,
                       input logic map4);
        @(posedge clk_sys);
        cfgMode <= m;
        cfgPeriodUs <= 16'h0002;
        cfgFallback0 <= fb0;
        cfgFallback1 <= fb1;
        cfgDataOnlyMap <= map4;
        cfgWrite <= 1'b1;
        @(posedge clk_sys);
        cfgWrite <= 1'b0;
    endtask

    // waits two periods for the boundary, then counts high cycles over one period
    task automatic measure(input logic [15:0] e0, input logic [15:0] e1);
        logic [15:0] n0;
        logic [15:0] n1;
        n0 = 0;
        n1 = 0;
        repeat (200) @(posedge clk_sys);
        repeat (100) begin
            @(negedge clk_sys);
            n0 += 16'(pwmOut[0] === 1'b1);
            n1 += 16'(pwmOut[1] === 1'b1);
        end
        check("duty ch0", n0, e0);
        check("duty ch1", n1, e1);
    endtask

    task automatic duty(input logic [15:0] d0, input logic [15:0] d1, input logic [15:0] e0,
                        input logic [15:0] e1);
        cpl_u.send({8'h00, d1, 8'h00, d0});
        measure(e0, e1);
    endtask

    // ***********************************
    // scenarios
    // ***********************************
    task automatic resetState;
        resetDut(1'b0);
        repeat (3) @(negedge clk_sys);
        check("image bytes", 16'(imageBytes), 16'h0006);
        check("default period", dut_u.period_r, 16'h0FA0);
        check("run led", 16'(runLed), 16'h0000);
        check("pwm pins", 16'(pwmOut), 16'h0000);
    endtask

    task automatic highSide;
        cfg(pwm_out_pkg::MODE_PWM, 16'h7FFF, 16'h0000, 1'b0);
        duty(16'h3FFF, 16'h7FFF, 16'h0031, 16'h0064);
        duty(16'h7FFE, 16'h8000, 16'h0064, 16'h0000);
        duty(16'h0000, 16'hFFFF, 16'h0000, 16'h0000);
    endtask

    // last image leaves ch0 at 0 %, fallback must force it to 100 %
    task automatic watchdog;
        repeat (WD + 5) @(posedge clk_sys);
        @(negedge clk_sys);
        check("wd flag", 16'(wdOverflow), 16'h0001);
        check("run led off", 16'(runLed), 16'h0000);
        check("wd status", 16'(pdIn[0].status[0]), 16'h0001);
        measure(16'h0064, 16'h0000);
        cpl_u.send({8'h00, 16'h0000, 8'h00, 16'h0000});
        repeat (3) @(negedge clk_sys);
        check("wd clear", 16'(wdOverflow), 16'h0000);
        check("run led on", 16'(runLed), 16'h0001);
    endtask

    task automatic lowSide;
        resetDut(1'b1);
        cfg(pwm_out_pkg::MODE_PWM, 16'h0000, 16'h0000, 1'b0);
        duty(16'h7FFF, 16'hFFFF, 16'h0000, 16'h0000);
        duty(16'h0000, 16'h8000, 16'h0064, 16'h0064);
        duty(16'hBFFF, 16'h3FFF, 16'h0032, 16'h0032);
        duty(16'h0001, 16'h7FFF, 16'h0063, 16'h0000);
    endtask

    task automatic stepper;
        logic [15:0] c0;
        logic [15:0] c1;
        logic [15:0] up;
        logic [15:0] down;
        resetDut(1'b0);
        cfg(pwm_out_pkg::MODE_STEPPER, 16'h0000, 16'h0000, 1'b0);
        cpl_u.send({8'h80, 16'h0055, 8'h00, 16'h0100});
        cpl_u.send({8'h81, 16'h0055, 8'h01, 16'h0100});
        repeat (4) @(negedge clk_sys);
        check("loaded count", pdIn[0].data, 16'h0100);
        check("refused load", pdIn[1].data, 16'h0000);
        cpl_u.send({8'h00, 16'h8001, 8'h01, 16'h7FFF});
        repeat (3) @(negedge clk_sys);
        c0 = pdIn[0].data;
        c1 = pdIn[1].data;
        // window kept below the watchdog span so the fallback never cuts in
        repeat (900) @(negedge clk_sys);
        up = pdIn[0].data - c0;
        down = c1 - pdIn[1].data;
        check("count up", 16'(up == 16'd4 || up == 16'd5), 16'h0001);
        check("count down", 16'(down == 16'd4 || down == 16'd5), 16'h0001);
        check("dir pins", 16'(dirOut), 16'h0002);
        check("dir status", 16'(pdIn[1].status[2]), 16'h0001);
    endtask

    // rising edges of the square wave over 900 cycles at 32767 x 8 Hz
    task automatic freqMod;
        logic [15:0] edges;
        logic last;
        edges = 0;
        cfg(pwm_out_pkg::MODE_FREQ_MODULATION, 16'h0000, 16'h0000, 1'b0);
        cpl_u.send({8'h00, 16'h0000, 8'h00, 16'h7FFF});
        repeat (3) @(negedge clk_sys);
        last = pwmOut[0];
        repeat (900) begin
            @(negedge clk_sys);
            edges += 16'(pwmOut[0] === 1'b1 && last === 1'b0);
            last = pwmOut[0];
        end
        check("fm edges", 16'(edges == 16'd4 || edges == 16'd5), 16'h0001);
    endtask

    task automatic dataOnly;
        cfg(pwm_out_pkg::MODE_PWM, 16'h0000, 16'h0000, 1'b1);
        repeat (3) @(negedge clk_sys);
        check("short image", 16'(imageBytes), 16'h0004);
        check("status gone", 16'(pdIn[0].status), 16'h0000);
    endtask

    // ***********************************
    // main sequence and watchdog
    // ***********************************
    initial begin
        resetn = 1'b0;
        lowSideVariant = 1'b0;
        cfgWrite = 1'b0;
        cfgDataOnlyMap = 1'b0;
        cfgMode = pwm_out_pkg::MODE_PWM;
        cfgPeriodUs = 16'h0FA0;
        cfgFallback0 = 16'h0000;
        cfgFallback1 = 16'h0000;
        resetState();
        highSide();
        watchdog();
        lowSide();
        stepper();
        freqMod();
        dataOnly();
        testDone();
    end

    // whole run is about 5300 cycles; give it well over twice that
    initial begin
        repeat (30000) @(posedge clk_sys);
        errorCnt++;
        testDone();
    end
endmodule
